// >>> include/flash_suspend_pkg.sv
// Constants and carrier types for the flash suspend and resume controller
`default_nettype none
package flash_suspend_pkg;

	// ==========================================================
	// Instruction codes
	localparam logic [7:0] OPC_ERASE_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_ERASE_RESUME  = 8'h7A;
	localparam logic [7:0] OPC_PROG_SUSPEND  = 8'h85;
	localparam logic [7:0] OPC_PROG_RESUME   = 8'h8A;
	localparam logic [7:0] OPC_READ_STATUS   = 8'h05;
	localparam logic [7:0] OPC_READ_PARAM    = 8'h5A;

	// ==========================================================
	// Status register layout
	localparam int         STATUS_WIP_BIT = 0;
	localparam logic [7:0] STATUS_RESET   = 8'h00;

	// ==========================================================
	// Parameter table words, byte address of the first one
	localparam logic [23:0] PARAM_BASE_ADDR = 24'h00002C;
	localparam logic [23:0] PARAM_END_ADDR  = 24'h000038;
	localparam logic [31:0] PARAM_SUSPEND_DWORD = 32'h451883EC;
	localparam logic [31:0] PARAM_OPCODE_DWORD  = 32'h757A858A;
	localparam logic [31:0] PARAM_POWER_DWORD   = 32'hFFFFFFF7;
	localparam logic [7:0]  PARAM_BLANK_BYTE    = 8'hFF;

	// ==========================================================
	// Frame layout: command, three address bytes, one dummy byte
	localparam logic [2:0] BYTE_CMD      = 3'h0;
	localparam logic [2:0] BYTE_ADDR_END = 3'h3;
	localparam logic [2:0] BYTE_DUMMY    = 3'h4;
	localparam logic [2:0] BYTE_DATA     = 3'h5;
	localparam logic [2:0] BIT_LAST      = 3'h7;

	// ==========================================================
	// Timing
	localparam int CLK_FREQ_MHZ          = 200;
	localparam int ERASE_SUSP_MAX_US     = 48;
	localparam int PROG_SUSP_MAX_US      = 40;
	localparam int RESUME_SUSP_MIN_US    = 128;
	localparam int ERASE_SUSP_MAX_CYCLES = ERASE_SUSP_MAX_US * CLK_FREQ_MHZ;
	localparam int PROG_SUSP_MAX_CYCLES  = PROG_SUSP_MAX_US * CLK_FREQ_MHZ;
	localparam int LAT_CNT_W             = 16;

	// ==========================================================
	// Operation states
	typedef enum logic [2:0] {
		OP_IDLE,
		OP_ERASE,
		OP_ERASE_SUSPENDING,
		OP_ERASE_SUSPENDED,
		OP_PROGRAM,
		OP_PROG_SUSPENDING,
		OP_PROG_SUSPENDED
	} op_state_e;

	// Requests and answers of the embedded algorithm engine
	typedef struct packed {
		logic erase_start;
		logic program_start;
		logic op_done;
		logic paused;
	} engine_in_s;

	// Operation status seen by the rest of the device
	typedef struct packed {
		logic write_in_progress_flag;
		logic erase_suspended;
		logic program_suspended;
	} op_status_s;

	// Complete register state of the controller
	typedef struct packed {
		logic [2:0]           sck_sync;
		logic [2:0]           cs_n_sync;
		logic [2:0]           mosi_sync;
		logic                 sck_lvl;
		logic                 cs_n_lvl;
		logic [7:0]           shift_in;
		logic [2:0]           bit_cnt;
		logic [2:0]           byte_cnt;
		logic [7:0]           cmd;
		logic [23:0]          addr;
		logic [7:0]           shift_out;
		logic                 miso;
		logic                 driving;
		op_state_e            op_state;
		logic [LAT_CNT_W-1:0] lat_cnt;
	} ctrl_state_s;

endpackage
`default_nettype wire

// >>> hdl/flash_suspend_resume_control.sv
// Serial suspend and resume controller for embedded program and erase
//
// Functional notes
// R01 - Instruction 75h suspends an erase in progress.
// R02 - Instruction 7Ah resumes a suspended erase.
// R03 - Instruction 85h suspends a page program in progress.
// R04 - Instruction 8Ah resumes a suspended program.
// R05 - Erase reaches suspended state within 48 us of the request.
// R06 - Host waits 128 us after erase resume before next erase suspend.
// R07 - Program reaches suspended state within 40 us of the request.
// R08 - Host waits 128 us after program resume before next program suspend.
// R09 - During erase suspend host starts no erase, no program or read in sector.
// R10 - During program suspend host starts no erase or program, no read in page.
// R11 - Parameter table reports suspend settings as word 45_18_83_EC.
// R12 - Parameter table marks deep power down unsupported with bit set.
// R13 - Parameter table marks suspend and resume supported with bit cleared.
// R14 - Status read 05h returns bit 0 high while busy, low when ready.
// R15 - Suspend or resume with no matching operation is ignored.
`timescale 1ns/1ps
`default_nettype none

module flash_suspend_resume_control
	import flash_suspend_pkg::*;
#(
	parameter int ERASE_SUSP_CYCLES = ERASE_SUSP_MAX_CYCLES,
	parameter int PROG_SUSP_CYCLES  = PROG_SUSP_MAX_CYCLES
) (
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	output logic            miso_o,
	output logic            miso_oe_n_o,
	input  wire engine_in_s engine_i,
	output logic            engine_pause_o,
	output op_status_s      status_o
);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] param_byte(input logic [23:0] a);
		logic [23:0] off;
		logic [31:0] word;
		off = a - PARAM_BASE_ADDR;
		case (off[3:2])
			2'h0:    word = PARAM_SUSPEND_DWORD; // [R11] [R13]
			2'h1:    word = PARAM_OPCODE_DWORD;
			default: word = PARAM_POWER_DWORD;   // [R12]
		endcase
		if (a < PARAM_BASE_ADDR || a >= PARAM_END_ADDR) begin
			param_byte = PARAM_BLANK_BYTE;
		end else begin
			param_byte = word[off[1:0]*8 +: 8];
		end
	endfunction

	function automatic logic wip_of(input op_state_e st);
		wip_of = (st == OP_ERASE) || (st == OP_ERASE_SUSPENDING) ||
			(st == OP_PROGRAM) || (st == OP_PROG_SUSPENDING);
	endfunction

	localparam logic [LAT_CNT_W-1:0] ERASE_LAT_LAST = LAT_CNT_W'(ERASE_SUSP_CYCLES - 1);
	localparam logic [LAT_CNT_W-1:0] PROG_LAT_LAST  = LAT_CNT_W'(PROG_SUSP_CYCLES - 1);

	ctrl_state_s s;
	ctrl_state_s next_s;

	// ==========================================================
	// Next state
	always_comb begin
		logic       sck_rise;
		logic       sck_fall;
		logic       cs_rise;
		logic       byte_done;
		logic [7:0] rx_byte;
		logic [7:0] cur_cmd;
		logic [7:0] status_byte;
		logic [7:0] exec_cmd;
		logic       exec;
		sck_rise    = 1'b0;
		sck_fall    = 1'b0;
		cs_rise     = 1'b0;
		byte_done   = 1'b0;
		rx_byte     = {s.shift_in[6:0], s.mosi_sync[2]};
		cur_cmd     = (s.byte_cnt == BYTE_CMD) ? rx_byte : s.cmd;
		status_byte = STATUS_RESET;
		status_byte[STATUS_WIP_BIT] = wip_of(s.op_state); // [R14]
		exec_cmd    = s.cmd;
		exec        = 1'b0;
		next_s      = s;

		// Pins pass three stages; a level counts once stages two and three agree
		next_s.sck_sync  = {s.sck_sync[1:0], sck_i};
		next_s.cs_n_sync = {s.cs_n_sync[1:0], cs_n_i};
		next_s.mosi_sync = {s.mosi_sync[1:0], mosi_i};
		if (s.sck_sync[1] == s.sck_sync[2] && s.sck_sync[2] != s.sck_lvl) begin
			next_s.sck_lvl = s.sck_sync[2];
			sck_rise       = s.sck_sync[2];
			sck_fall       = !s.sck_sync[2];
		end
		if (s.cs_n_sync[1] == s.cs_n_sync[2] && s.cs_n_sync[2] != s.cs_n_lvl) begin
			next_s.cs_n_lvl = s.cs_n_sync[2];
			cs_rise         = s.cs_n_sync[2];
		end

		// ======================================================
		// Serial frame
		if (s.cs_n_lvl) begin
			next_s.bit_cnt  = 3'h0;
			next_s.byte_cnt = BYTE_CMD;
			next_s.driving  = 1'b0;
		end else if (sck_rise) begin
			next_s.shift_in = rx_byte;
			next_s.bit_cnt  = s.bit_cnt + 3'h1;
			byte_done       = (s.bit_cnt == BIT_LAST);
		end else if (sck_fall && s.driving) begin
			next_s.miso      = s.shift_out[7];
			next_s.shift_out = {s.shift_out[6:0], 1'b0};
		end

		if (byte_done) begin
			if (s.byte_cnt != BYTE_DATA) begin
				next_s.byte_cnt = s.byte_cnt + 3'h1;
			end
			if (s.byte_cnt == BYTE_CMD) begin
				next_s.cmd = rx_byte;
			end
			if (cur_cmd == OPC_READ_STATUS) begin
				// Reloaded every byte so polling sees the live busy bit
				next_s.shift_out = status_byte; // [R14]
				next_s.driving   = 1'b1;
			end else if (cur_cmd == OPC_READ_PARAM) begin
				if (s.byte_cnt != BYTE_CMD && s.byte_cnt <= BYTE_ADDR_END) begin
					next_s.addr = {s.addr[15:0], rx_byte};
				end else if (s.byte_cnt == BYTE_DUMMY) begin
					next_s.shift_out = param_byte(s.addr); // [R11] [R12] [R13]
					next_s.driving   = 1'b1;
				end else if (s.byte_cnt == BYTE_DATA) begin
					next_s.addr      = s.addr + 24'h000001;
					next_s.shift_out = param_byte(s.addr + 24'h000001);
				end
			end
		end

		// Suspend and resume act when a frame of exactly one byte closes
		if (cs_rise && s.byte_cnt == 3'h1 && s.bit_cnt == 3'h0) begin
			exec     = 1'b1;
			exec_cmd = s.cmd;
		end

		// ======================================================
		// Operation sequencer
		case (s.op_state)
			OP_IDLE: begin
				next_s.lat_cnt = '0;
				if (engine_i.erase_start) begin
					next_s.op_state = OP_ERASE;
				end else if (engine_i.program_start) begin
					next_s.op_state = OP_PROGRAM;
				end
			end
			OP_ERASE: begin
				if (engine_i.op_done) begin
					next_s.op_state = OP_IDLE;
				end else if (exec && exec_cmd == OPC_ERASE_SUSPEND) begin // [R01]
					next_s.op_state = OP_ERASE_SUSPENDING;
					next_s.lat_cnt  = '0;
				end
			end
			OP_ERASE_SUSPENDING: begin
				next_s.lat_cnt = s.lat_cnt + 1'b1;
				if (engine_i.op_done) begin
					next_s.op_state = OP_IDLE;
				end else if (engine_i.paused || s.lat_cnt >= ERASE_LAT_LAST) begin
					next_s.op_state = OP_ERASE_SUSPENDED; // [R05]
				end
			end
			OP_ERASE_SUSPENDED: begin
				// Starts from the engine are not nested here; the host keeps off [R09]
				if (exec && exec_cmd == OPC_ERASE_RESUME) begin // [R02]
					next_s.op_state = OP_ERASE;
				end
			end
			OP_PROGRAM: begin
				if (engine_i.op_done) begin
					next_s.op_state = OP_IDLE;
				end else if (exec && exec_cmd == OPC_PROG_SUSPEND) begin // [R03]
					next_s.op_state = OP_PROG_SUSPENDING;
					next_s.lat_cnt  = '0;
				end
			end
			OP_PROG_SUSPENDING: begin
				next_s.lat_cnt = s.lat_cnt + 1'b1;
				if (engine_i.op_done) begin
					next_s.op_state = OP_IDLE;
				end else if (engine_i.paused || s.lat_cnt >= PROG_LAT_LAST) begin
					next_s.op_state = OP_PROG_SUSPENDED; // [R07]
				end
			end
			OP_PROG_SUSPENDED: begin
				// No nested erase or program while suspended [R10]
				if (exec && exec_cmd == OPC_PROG_RESUME) begin // [R04]
					next_s.op_state = OP_PROGRAM;
				end
			end
			default: begin
				next_s.op_state = OP_IDLE;
			end
		endcase
		// Any other instruction in any other state simply falls through [R15]
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s           <= '0;
			s.sck_sync  <= 3'h0;
			s.cs_n_sync <= 3'h7;
			s.cs_n_lvl  <= 1'b1;
			s.op_state  <= OP_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign miso_o         = s.miso;
	assign miso_oe_n_o    = !s.driving;
	assign engine_pause_o = (s.op_state == OP_ERASE_SUSPENDING) ||
		(s.op_state == OP_ERASE_SUSPENDED) || (s.op_state == OP_PROG_SUSPENDING) ||
		(s.op_state == OP_PROG_SUSPENDED);
	assign status_o.write_in_progress_flag = wip_of(s.op_state); // [R14]
	assign status_o.erase_suspended        = (s.op_state == OP_ERASE_SUSPENDED);
	assign status_o.program_suspended      = (s.op_state == OP_PROG_SUSPENDED);

endmodule
`default_nettype wire

// >>> test/flash_suspend_assertions.sv
// Port assertions for the suspend and resume controller
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_assertions
	import flash_suspend_pkg::*;
#(
	parameter int ERASE_SUSP_CYCLES = 20,
	parameter int PROG_SUSP_CYCLES  = 16
) (
	input wire logic       clock_i,
	input wire logic       reset_n_i,
	input wire logic       sck_i,
	input wire logic       cs_n_i,
	input wire logic       mosi_i,
	input wire logic       miso_o,
	input wire logic       miso_oe_n_o,
	input wire engine_in_s engine_i,
	input wire logic       engine_pause_o,
	input wire op_status_s status_o
);
	// ==========================================
	// Helper: kind of operation and cycles spent suspending
	logic        erasing;
	logic [15:0] wait_cnt;
	wire logic   idle = !status_o.write_in_progress_flag && !engine_pause_o;
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			erasing  <= 1'b0;
			wait_cnt <= '0;
		end else begin
			if (idle && (engine_i.erase_start || engine_i.program_start))
				erasing <= engine_i.erase_start;
			wait_cnt <= (engine_pause_o && status_o.write_in_progress_flag) ? wait_cnt + 1'b1 : '0;
		end
	end
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	// ==========================================
	// Assertions
	a_erase_susp_bound: assert property (erasing |-> wait_cnt <= ERASE_SUSP_CYCLES)
		else $error("erase suspend too slow");
	a_prog_susp_bound: assert property (!erasing |-> wait_cnt <= PROG_SUSP_CYCLES)
		else $error("program suspend too slow");
	a_pause_needs_work: assert property ($rose(engine_pause_o) |-> $past(status_o.write_in_progress_flag) && cs_n_i)
		else $error("pause without operation or frame");
	a_suspended_quiet: assert property ((status_o.erase_suspended || status_o.program_suspended) |-> engine_pause_o && !status_o.write_in_progress_flag)
		else $error("suspended but busy");
	a_erase_resumes: assert property ($fell(status_o.erase_suspended) |-> status_o.write_in_progress_flag && !engine_pause_o)
		else $error("erase resume wrong");
	a_prog_resumes: assert property ($fell(status_o.program_suspended) |-> status_o.write_in_progress_flag && !engine_pause_o)
		else $error("program resume wrong");
	a_start_sets_busy: assert property (idle && (engine_i.erase_start || engine_i.program_start) |=> status_o.write_in_progress_flag)
		else $error("start not busy");
	a_deselect_release: assert property (cs_n_i [*6] |-> miso_oe_n_o)
		else $error("data driven while deselected");
	a_miso_on_low_sck: assert property (!$stable(miso_o) |-> !sck_i)
		else $error("data changed with clock high");
	c_erase_susp: cover property (status_o.erase_suspended);
	c_prog_susp: cover property (status_o.program_suspended);
	c_read_out: cover property (!miso_oe_n_o);
endmodule
`default_nettype wire

// >>> test/spi_host_model.sv
// Serial host model that frames instructions for the controller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// ==========================================
	// Mode 0, MSB first; the link clock runs only inside a frame
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#80;
			sck_o = 1'b1;
			rx[i] = miso_i;
			#80;
			sck_o = 1'b0;
		end
	endtask
	task automatic open_frame();
		#40;
		cs_n_o = 1'b0;
		#80;
	endtask
	// Data line flips on release so a stale bit is never mistaken for data
	task automatic close_frame();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
	// Only suspend, resume, status and table reads are issued
	task automatic instr(input logic [7:0] code);
		logic [7:0] rx;
		open_frame();
		xfer(code, rx);
		close_frame();
	endtask
	task automatic poll_status(output logic busy);
		logic [7:0] rx;
		open_frame();
		xfer(8'h05, rx);
		xfer(8'h00, rx);
		close_frame();
		busy = rx[0];
	endtask
endmodule
`default_nettype wire

// >>> test/flash_suspend_resume_control_test.sv
// Self-checking bench for the suspend and resume controller
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_control_test import flash_suspend_pkg::*;;
	localparam int ES = 20;
	localparam int PS = 16;
	logic       clock_i;
	logic       reset_n_i;
	logic       sck, cs_n, mosi, miso, miso_oe_n, pause;
	engine_in_s eng;
	op_status_s st;
	int         fail_count;
	int         samples_checked;
	// Released data line idles high
	wire logic  miso_w = miso_oe_n ? 1'b1 : miso;
	flash_suspend_resume_control #(.ERASE_SUSP_CYCLES(ES), .PROG_SUSP_CYCLES(PS))
	flash_suspend_resume_control_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .sck_i(sck),
		.cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
		.engine_i(eng), .engine_pause_o(pause), .status_o(st));
	spi_host_model spi_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic pulse(input engine_in_s p);
		@(posedge clock_i);
		eng <= p | {3'b000, eng.paused};
		@(posedge clock_i);
		eng <= {3'b000, eng.paused};
		#1;
	endtask
	task automatic wait_susp(input logic er, input logic v, output int n);
		for (n = 0; n < 60 && (er ? st.erase_suspended : st.program_suspended) !== v; n++) begin
			@(posedge clock_i);
			#1;
		end
	endtask
	// Suspend with a slow or a prompt engine, then resume
	task automatic susp_res(input logic [7:0] sc, rc, input int lim, input logic er, prompt);
		int   n;
		logic b;
		spi_host_model_i.instr(sc);
		@(posedge clock_i);
		eng.paused <= prompt;
		wait_susp(er, 1'b1, n);
		chk("latency", n <= (prompt ? 8 : lim + 8), 1);
		chk("busy", st.write_in_progress_flag, 0);
		chk("pause held", pause, 1);
		spi_host_model_i.poll_status(b);
		chk("busy bit", b, 0);
		@(posedge clock_i);
		eng.paused <= 1'b0;
		spi_host_model_i.instr(rc);
		wait_susp(er, 1'b0, n);
		chk("resume", {n < 60, st.write_in_progress_flag, pause}, 3'b110);
		spi_host_model_i.poll_status(b);
		chk("busy bit", b, 1);
	endtask
	// ==========================================
	// Scenarios
	task automatic test_erase();
		pulse(4'b1000);
		chk("erase busy", st.write_in_progress_flag, 1);
		susp_res(8'h75, 8'h7A, ES, 1'b1, 1'b0);
		repeat (25600) @(posedge clock_i);
		susp_res(8'h75, 8'h7A, ES, 1'b1, 1'b1);
		pulse(4'b0010);
		chk("erase done", st.write_in_progress_flag, 0);
		$display("erase test done");
	endtask
	task automatic test_program();
		pulse(4'b0100);
		susp_res(8'h85, 8'h8A, PS, 1'b0, 1'b1);
		repeat (25600) @(posedge clock_i);
		susp_res(8'h85, 8'h8A, PS, 1'b0, 1'b0);
		pulse(4'b0010);
		$display("program test done");
	endtask
	task automatic test_ignore();
		logic [7:0] codes [4] = '{8'h75, 8'h7A, 8'h85, 8'h8A};
		foreach (codes[i])
			spi_host_model_i.instr(codes[i]);
		repeat (10) @(posedge clock_i);
		#1;
		chk("idle codes", {pause, st}, 4'b0000);
		pulse(4'b1000);
		spi_host_model_i.instr(8'h85);
		repeat (10) @(posedge clock_i);
		#1;
		chk("wrong kind", {pause, st}, 4'b0100);
		pulse(4'b0010);
		$display("ignore test done");
	endtask
	task automatic test_table();
		logic [7:0]  rx;
		logic [31:0] w [3];
		spi_host_model_i.open_frame();
		spi_host_model_i.xfer(8'h5A, rx);
		spi_host_model_i.xfer(8'h00, rx);
		spi_host_model_i.xfer(8'h00, rx);
		spi_host_model_i.xfer(8'h2C, rx);
		spi_host_model_i.xfer(8'h00, rx);
		for (int i = 0; i < 12; i++) begin
			spi_host_model_i.xfer(8'h00, rx);
			w[i / 4][8 * (i % 4) +: 8] = rx;
		end
		// One byte past the table must read blank
		spi_host_model_i.xfer(8'h00, rx);
		chk("past table", rx, 8'hFF);
		spi_host_model_i.close_frame();
		repeat (8) @(posedge clock_i);
		#1;
		chk("released", miso_oe_n, 1);
		chk("suspend word", w[0], 32'h451883EC);
		chk("suspend support", w[0][31], 0);
		chk("opcode word", w[1], 32'h757A858A);
		chk("power down", w[2][31], 1);
		chk("power word", w[2], 32'hFFFFFFF7);
		$display("table test done");
	endtask
	// ==========================================
	// Clock, sequence and watchdog
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	initial begin
		reset_n_i = 1'b0;
		eng = '0;
		fail_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		test_erase();
		test_program();
		test_ignore();
		test_table();
		conclude();
	end
	initial begin
		// Tests need about 320 us; the limit keeps a hang under 100k cycles
		#420us;
		fail_count++;
		conclude();
	end
endmodule
bind flash_suspend_resume_control flash_suspend_assertions #(
	.ERASE_SUSP_CYCLES(ERASE_SUSP_CYCLES), .PROG_SUSP_CYCLES(PROG_SUSP_CYCLES)
) chk_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
	.mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .engine_i(engine_i),
	.engine_pause_o(engine_pause_o), .status_o(status_o));
`default_nettype wire
